// file: design/curve_mem.sv
// Sample store for the recorded LED characteristic.
// Assumes one write port and one registered read port.
`timescale 1ns/1ps
`default_nettype none
module curve_mem #(
   parameter int depth = 64,
   parameter int aw = 6,
   parameter int dw = 32
) (
   // Clock
   input wire logic clk_i,
   // Write port
   input wire logic we_i,
   input wire logic [aw-1:0] waddr_i,
   input wire logic [dw-1:0] wdata_i,
   // Read port
   input wire logic [aw-1:0] raddr_i,
   output logic [dw-1:0] rdata_o
);
   logic [dw-1:0] mem [depth];
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end
   always_ff @(posedge clk_i) begin
      rdata_o <= mem[raddr_i];
   end
endmodule
`default_nettype wire

// file: design/led_trigger_gate.sv
// Trigger input qualification, output gating and curve upload store.
// Assumes a classic Wishbone master and a measurement front end
// that strobes voltage and current samples.
`timescale 1ns/1ps
`default_nettype none
module led_trigger_gate
   import strobe_gate_pkg::*;
#(
   parameter int cnt_w = 16,
   parameter int depth = 64,
   parameter int aw = 6
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Trigger input pin pair, differential level taken as one level
   input wire logic trigger_input_positive_i,
   // Measurement front end
   input wire logic sample_i,
   input wire logic [15:0] volt_i,
   input wire logic [15:0] amp_i,
   input wire logic teach_done_i,
   // Outputs to the power stage
   output logic led_on_o,
   output logic [15:0] led_current_o,
   output logic trig_out_o,
   output logic hw_active_o
);
   logic [ctrl_w-1:0] output_control_word;
   logic [mode_w-1:0] op_mode;
   logic [15:0] output_current_setpoint;
   logic [cnt_w-1:0] pulse_len;
   logic [cnt_w-1:0] pulse_dly;
   logic file_sel;
   logic [aw-1:0] rd_ptr;
   logic [aw-1:0] wr_ptr;
   logic [aw:0] count;
   logic curve_valid;
   logic recording;
   logic out_d;
   logic [cnt_w-1:0] timer;
   pulse_state_t state;
   pulse_state_t next_state;
   logic in_active;
   logic in_rise;
   logic [31:0] mem_rdata;
   logic bus_req;
   logic wr_en;
   logic rd_en;
   logic enable;
   logic out_bit;
   logic hw_mode;
   logic gate;
   logic pulse_mode;
   logic led_next;
   logic rec_cond;
   logic mem_we;
   logic row_avail;
   logic [31:0] status_word;
   logic trig_next;

   assign bus_req = cyc_i & stb_i & ~ack_o;
   assign wr_en = bus_req & we_i & sel_i[0];
   assign rd_en = bus_req & ~we_i;
   assign enable = output_control_word[ctrl_enable_bit];
   assign out_bit = output_control_word[ctrl_output_bit];
   assign hw_mode = output_control_word[ctrl_in_func_bit] == in_func_hw_en;
   assign pulse_mode = op_mode == mode_trig_pulse;

   // Polarity applied past the synchroniser, never on the raw pin
   trig_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .trig_raw_i(trigger_input_positive_i),
      .invert_i(output_control_word[ctrl_invert_bit]),
      .active_o(in_active),
      .rise_o(in_rise)
   );

   // Hardware enable: outputs live only while input active
   assign gate = hw_mode ? in_active : 1'b1;

   // Wishbone acknowledge, one cycle after the request
   // Masked by ack itself, so a held strobe is answered every other cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= bus_req;
      end
   end

   // Control word; reset leaves edge use selected
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         output_control_word <= ctrl_reset;
      end else if (wr_en && adr_i == ctrl_addr) begin
         output_control_word <= dat_i[ctrl_w-1:0];
      end
   end

   // Operation mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op_mode <= mode_reset;
      end else if (wr_en && adr_i == mode_addr) begin
         op_mode <= dat_i[mode_w-1:0];
      end
   end

   // Current setpoint in mA
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         output_current_setpoint <= 16'h0000;
      end else if (wr_en && adr_i == current_addr) begin
         output_current_setpoint <= dat_i[15:0];
      end
   end

   // Pulse timing in clock cycles
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse_len <= pulse_reset[cnt_w-1:0];
         pulse_dly <= pulse_reset[cnt_w-1:0];
      end else if (wr_en) begin
         if (adr_i == pulse_len_addr) begin
            pulse_len <= dat_i[cnt_w-1:0];
         end else if (adr_i == pulse_dly_addr) begin
            pulse_dly <= dat_i[cnt_w-1:0];
         end
      end
   end

   // Edge-launched pulse: delay then duration
   always_comb begin
      next_state = state;
      case (state)
         pulse_idle: begin
            if (!hw_mode && pulse_mode && enable && in_rise) begin
               next_state = pulse_wait;
            end
         end
         pulse_wait: begin
            if (timer == '0) begin
               next_state = pulse_on;
            end
         end
         pulse_on: begin
            if (timer == '0) begin
               next_state = pulse_idle;
            end
         end
         default: next_state = pulse_idle;
      endcase
      if (hw_mode || !pulse_mode || !enable) begin
         next_state = pulse_idle;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= pulse_idle;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer <= '0;
      end else if (state == pulse_idle) begin
         timer <= pulse_dly;
      end else if (state == pulse_wait && timer == '0) begin
         timer <= pulse_len - 1'b1;
      end else if (timer != '0) begin
         timer <= timer - 1'b1;
      end
   end

   // Trigger output: enable bit, gated by input level in hardware use
   always_comb begin
      if (hw_mode) begin
         trig_next = output_control_word[ctrl_trig_en_bit] & in_active;
      end else begin
         trig_next = output_control_word[ctrl_trig_en_bit];
      end
   end

   // LED drive selection per input function and mode
   always_comb begin
      if (hw_mode) begin
         led_next = enable & out_bit & gate;
      end else if (pulse_mode) begin
         led_next = state == pulse_on;
      end else begin
         led_next = enable & out_bit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         led_on_o <= 1'b0;
         trig_out_o <= 1'b0;
         hw_active_o <= 1'b0;
         led_current_o <= 16'h0000;
      end else begin
         led_on_o <= led_next;
         trig_out_o <= trig_next;
         hw_active_o <= hw_mode & in_active;
         led_current_o <= led_next ? output_current_setpoint : 16'h0000;
      end
   end

   // Recording runs while enable and output bits are set in current-regulated mode
   assign rec_cond = op_mode == mode_current && enable && out_bit;
   assign mem_we = recording & sample_i & (count <= (aw+1)'(depth - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_d <= 1'b0;
         recording <= 1'b0;
      end else begin
         out_d <= out_bit;
         recording <= rec_cond;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         count <= '0;
      end else if (rec_cond && !recording) begin
         wr_ptr <= '0;
         count <= '0;
      end else if (mem_we) begin
         wr_ptr <= wr_ptr + 1'b1;
         count <= count + 1'b1;
      end
   end

   // Curve offered after teach-in or a recording ended by clearing the output bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         curve_valid <= 1'b0;
      end else if (teach_done_i) begin
         curve_valid <= 1'b1;
      end else if (recording && !rec_cond && out_d && !out_bit) begin
         curve_valid <= 1'b1;
      end else if (rec_cond && !recording) begin
         curve_valid <= 1'b0;
      end
   end

   // Row: voltage in 0.01 V over current in mA
   curve_mem #(
      .depth(depth),
      .aw(aw),
      .dw(32)
   ) u_mem (
      .clk_i(clk_i),
      .we_i(mem_we),
      .waddr_i(wr_ptr),
      .wdata_i({volt_i, amp_i}),
      .raddr_i(rd_ptr),
      .rdata_o(mem_rdata)
   );

   // Reads past the recorded rows return zero, not stale memory
   assign row_avail = curve_valid && ({1'b0, rd_ptr} < count);

   // File select restarts the upload; data reads walk the rows
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         file_sel <= file_table;
         rd_ptr <= '0;
      end else if (wr_en && adr_i == file_sel_addr) begin
         file_sel <= dat_i[0];
         rd_ptr <= '0;
      end else if (rd_en && adr_i == file_data_addr && row_avail) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // Status word assembled apart from the read mux
   always_comb begin
      status_word = read_zero;
      status_word[stat_valid_bit] = curve_valid;
      status_word[stat_hw_act_bit] = hw_mode & in_active;
      status_word[stat_led_bit] = led_on_o;
      status_word[stat_in_bit] = in_active;
      status_word[stat_rec_bit] = recording;
      status_word[31:16] = {{(15-aw){1'b0}}, count};
   end

   // Read data; memory output registered, table or plot layout
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= read_zero;
      end else if (rd_en) begin
         if (adr_i == ctrl_addr) begin
            dat_o <= {{(32-ctrl_w){1'b0}}, output_control_word};
         end else if (adr_i == mode_addr) begin
            dat_o <= {{(32-mode_w){1'b0}}, op_mode};
         end else if (adr_i == current_addr) begin
            dat_o <= {16'h0000, output_current_setpoint};
         end else if (adr_i == pulse_len_addr) begin
            dat_o <= {{(32-cnt_w){1'b0}}, pulse_len};
         end else if (adr_i == pulse_dly_addr) begin
            dat_o <= {{(32-cnt_w){1'b0}}, pulse_dly};
         end else if (adr_i == status_addr) begin
            dat_o <= status_word;
         end else if (adr_i == file_sel_addr) begin
            dat_o <= {31'h0000_0000, file_sel};
         end else if (adr_i == file_data_addr && row_avail) begin
            if (file_sel == file_plot) begin
               dat_o <= {mem_rdata[15:0], mem_rdata[31:16]};
            end else begin
               dat_o <= mem_rdata;
            end
         end else begin
            dat_o <= read_zero;
         end
      end
   end
endmodule
`default_nettype wire

// file: design/strobe_gate_pkg.sv
// Shared constants for the trigger input gate and curve store.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package strobe_gate_pkg;
   // Register byte offsets
   localparam logic [7:0] ctrl_addr = 8'h00;
   localparam logic [7:0] mode_addr = 8'h04;
   localparam logic [7:0] current_addr = 8'h08;
   localparam logic [7:0] pulse_len_addr = 8'h0c;
   localparam logic [7:0] pulse_dly_addr = 8'h10;
   localparam logic [7:0] status_addr = 8'h14;
   localparam logic [7:0] file_sel_addr = 8'h18;
   localparam logic [7:0] file_data_addr = 8'h1c;
   // Control word bits
   localparam int ctrl_enable_bit = 0;
   localparam int ctrl_output_bit = 1;
   localparam int ctrl_trig_en_bit = 2;
   localparam int ctrl_in_func_bit = 3;
   localparam int ctrl_invert_bit = 4;
   localparam int ctrl_w = 5;
   // Status bits
   localparam int stat_valid_bit = 0;
   localparam int stat_hw_act_bit = 1;
   localparam int stat_led_bit = 2;
   localparam int stat_in_bit = 3;
   localparam int stat_rec_bit = 4;
   // Operation modes
   localparam int mode_w = 3;
   localparam logic [2:0] mode_current = 3'h0;
   localparam logic [2:0] mode_trig_pulse = 3'h1;
   // Input function and file selection codes
   localparam logic in_func_edge = 1'b0;
   localparam logic in_func_hw_en = 1'b1;
   localparam logic file_table = 1'b0;
   localparam logic file_plot = 1'b1;
   // Reset values
   localparam logic [4:0] ctrl_reset = 5'h00;
   localparam logic [2:0] mode_reset = 3'h0;
   localparam logic [15:0] pulse_reset = 16'h0001;
   localparam logic [31:0] read_zero = 32'h0000_0000;
   typedef enum logic [1:0] {pulse_idle, pulse_wait, pulse_on} pulse_state_t;
endpackage

// file: design/trig_sync.sv
// Two-stage synchroniser for the trigger input, polarity and edge.
// Assumes the raw input level is asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module trig_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Trigger input
   input wire logic trig_raw_i,
   input wire logic invert_i,
   // Qualified level and edge
   output logic active_o,
   output logic rise_o
);
   logic meta;
   logic sync;
   logic sync_d;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= 1'b0;
         sync <= 1'b0;
         sync_d <= 1'b0;
      end else begin
         meta <= trig_raw_i;
         sync <= meta;
         sync_d <= sync;
      end
   end
   // Invert selects low-active enable
   assign active_o = sync ^ invert_i;
   assign rise_o = (sync ^ invert_i) & ~(sync_d ^ invert_i);
endmodule
`default_nettype wire

// file: testbench/flash_front.sv
// Camera flash source and measurement front end for the gate bench.
// Assumes the bench commands the flash level and sample bursts.
`timescale 1ns/1ps
`default_nettype none
module flash_front (
   // Clock and commands
   input wire logic clk_i,
   input wire logic level_i,
   input wire logic [7:0] burst_i,
   // Pin and samples
   output wire logic pin_o,
   output logic sample_o = 1'b0,
   output logic [15:0] volt_o = 16'h0000,
   output logic [15:0] amp_o = 16'h0000
);
   int left = 0;
   assign #13 pin_o = level_i;
   always @(posedge clk_i) begin
      sample_o <= 1'b0;
      volt_o <= ~volt_o;
      amp_o <= ~amp_o;
      if (burst_i != 8'h00) left <= int'(burst_i);
      else if (left > 0 && !sample_o) begin
         sample_o <= 1'b1;
         volt_o <= 16'(1500 + $urandom % 600);
         amp_o <= 16'($urandom % 300);
         left <= left - 1;
      end
   end
endmodule
`default_nettype wire

// file: testbench/led_gate_chk.sv
// Checker on the gate's ports: bus answer timing, output gating, latency.
// Assumes one clock domain and the top module's port names.
`timescale 1ns/1ps
`default_nettype none
module led_gate_chk (
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // Pin and outputs
   input wire logic trigger_input_positive_i,
   input wire logic led_on_o,
   input wire logic [15:0] led_current_o,
   input wire logic trig_out_o,
   input wire logic hw_active_o
);
   logic [3:0] pin_cnt;
   logic [3:0] bus_cnt;
   logic pin_q;
   always_ff @(posedge clk_i) begin
      pin_q <= trigger_input_positive_i;
      if (rst_i || pin_q != trigger_input_positive_i) pin_cnt <= 4'h0;
      else if (pin_cnt != 4'hf) pin_cnt <= pin_cnt + 4'h1;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || ack_o) bus_cnt <= 4'h0;
      else if (bus_cnt != 4'hf) bus_cnt <= bus_cnt + 4'h1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing after request");
   a_ack_idle: assert property (!(cyc_i && stb_i && !ack_o) |=> !ack_o)
      else $error("ack without request");
   a_data_holds: assert property ($changed(dat_o) |-> ack_o && !$past(we_i))
      else $error("read data moved outside a read answer");
   a_dark_current: assert property (!led_on_o |-> led_current_o == 16'h0000)
      else $error("current driven while dark");
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !led_on_o && !trig_out_o
      && !hw_active_o && !ack_o)
      else $error("outputs active after reset");
   a_hw_steady: assert property (pin_cnt >= 4'h4 && bus_cnt >= 4'h4 |-> $stable(hw_active_o))
      else $error("hardware enable moved with quiet pin");
   a_sync_delay: assert property (pin_cnt == 4'h0 && $past(pin_cnt) >= 4'h4 && bus_cnt >= 4'h4
      |-> $stable(hw_active_o))
      else $error("pin reached enable too fast");
   a_current_steady: assert property (led_on_o && $past(led_on_o) && bus_cnt >= 4'h2
      |-> $stable(led_current_o))
      else $error("current moved during a lit stretch");
endmodule
bind led_trigger_gate led_gate_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o,
   .ack_o, .trigger_input_positive_i, .led_on_o, .led_current_o, .trig_out_o, .hw_active_o);
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench: bus, edge pulse, hardware enable, curve upload.
// Assumes the package, the gate, its checker and the flash model.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import strobe_gate_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, level = 1'b0, teach = 1'b0;
   logic [7:0] adr_i = 8'h00, burst = 8'h00;
   logic [3:0] sel_i = 4'h1;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic [15:0] volt, amp, led_current_o;
   logic pin, sample, led_on_o, trig_out_o, hw_active_o;
   logic [31:0] rows[$];
   int bad_count = 0, n_tests = 0, cycles = 0, n, len, sp, act;
   led_trigger_gate u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .trigger_input_positive_i(pin), .sample_i(sample), .volt_i(volt),
      .amp_i(amp), .teach_done_i(teach), .led_on_o, .led_current_o, .trig_out_o, .hw_active_o);
   flash_front u_far (.clk_i, .level_i(level), .burst_i(burst), .pin_o(pin),
      .sample_o(sample), .volt_o(volt), .amp_o(amp));
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles > 3000) begin
         bad_count++;
         final_report();
      end
   end
   always @(posedge clk_i) if (sample === 1'b1) rows.push_back({volt, amp});
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'h1 | 4'($urandom);
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic count_led(input int k, output int c);
      c = 0;
      repeat (k) begin
         @(posedge clk_i);
         if (led_on_o === 1'b1) begin
            c++;
            cmp("led_current", 32'(sp), 32'(led_current_o));
         end
      end
   endtask
   initial begin
      void'($urandom(32'h1762));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, ctrl_addr, 32'h0);
      cmp("ctrl", 32'(ctrl_reset), rd);
      wb(1'b0, mode_addr, 32'h0);
      cmp("mode", 32'(mode_reset), rd);
      wb(1'b0, pulse_len_addr, 32'h0);
      cmp("pulse_len", 32'(pulse_reset), rd);
      wb(1'b0, file_data_addr, 32'h0);
      cmp("row_early", read_zero, rd);
      teach <= 1'b1;
      @(posedge clk_i);
      teach <= 1'b0;
      wb(1'b0, status_addr, 32'h0);
      cmp("teach_valid", 32'h1, 32'(rd[stat_valid_bit]));
      wb(1'b1, 8'h40, 32'hffff_ffff);
      wb(1'b0, 8'h40, 32'h0);
      cmp("unmapped", read_zero, rd);
      $display("test reset_values done");
      sp = 1 + $urandom % 1000;
      wb(1'b1, current_addr, 32'(sp));
      wb(1'b1, mode_addr, 32'h2);
      wb(1'b1, ctrl_addr, 32'h3);
      level <= 1'b1;
      count_led(12, n);
      cmp("plain_mode_led", 32'd12, 32'(n));
      level <= 1'b0;
      $display("test edge_other_mode done");
      len = 1 + $urandom % 8;
      wb(1'b1, pulse_len_addr, 32'(len));
      wb(1'b1, pulse_dly_addr, 32'($urandom % 4));
      wb(1'b1, mode_addr, 32'(mode_trig_pulse));
      wb(1'b1, ctrl_addr, 32'h1);
      level <= 1'b1;
      count_led(30, n);
      cmp("pulse_cycles", 32'(len), 32'(n));
      level <= 1'b0;
      count_led(20, n);
      cmp("falling_edge", 32'h0, 32'(n));
      $display("test edge_pulse done");
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, ctrl_addr, {27'h0, i[1], 4'hf});
         level <= i[0];
         act = i[0] ^ i[1];
         repeat (6) @(posedge clk_i);
         cmp("hw_trig", 32'(act), 32'(trig_out_o));
         cmp("hw_active", 32'(act), 32'(hw_active_o));
         count_led(12, n);
         cmp("hw_led", 32'(12 * act), 32'(n));
      end
      wb(1'b1, ctrl_addr, 32'h0d);
      level <= 1'b1;
      count_led(10, n);
      cmp("hw_no_output", 32'h0, 32'(n));
      $display("test hardware_enable done");
      wb(1'b1, ctrl_addr, 32'h0);
      wb(1'b1, mode_addr, 32'(mode_current));
      rows.delete();
      wb(1'b1, ctrl_addr, 32'h3);
      wb(1'b0, status_addr, 32'h0);
      cmp("valid_cleared", 32'h0, 32'(rd[stat_valid_bit]));
      cmp("recording", 32'h1, 32'(rd[stat_rec_bit]));
      n = 2 + $urandom % 10;
      burst <= 8'(n);
      @(posedge clk_i);
      burst <= 8'h00;
      repeat (2 * n + 4) @(posedge clk_i);
      wb(1'b1, ctrl_addr, 32'h0);
      wb(1'b0, status_addr, 32'h0);
      cmp("curve_valid", 32'h1, 32'(rd[stat_valid_bit]));
      cmp("sample_count", 32'(rows.size()), 32'(rd[31:16]));
      for (int f = 0; f < 2; f++) begin
         wb(1'b1, file_sel_addr, 32'(f));
         foreach (rows[k]) begin
            wb(1'b0, file_data_addr, 32'h0);
            cmp("row", f ? {rows[k][15:0], rows[k][31:16]} : rows[k], rd);
         end
      end
      wb(1'b0, file_data_addr, 32'h0);
      cmp("row_past_end", read_zero, rd);
      $display("test curve_upload done");
      final_report();
   end
endmodule
`default_nettype wire
